// ### hw/spr_defs.svh
`ifndef SPR_DEFS_SVH
`define SPR_DEFS_SVH

// register byte offsets on the bus
`define SPR_CTRL_OFS     8'h00
`define SPR_TXW_OFS      8'h04
`define SPR_RXW_OFS      8'h08
`define SPR_CFG_OFS      8'h0C

// control and config register bit positions
`define SPR_OVR_BIT      13
`define SPR_UDF_N_BIT    12
`define SPR_TX_RDY_BIT   11
`define SPR_RX_RDY_BIT   10
`define SPR_TX_LVL_BIT   9
`define SPR_RX_LVL_BIT   8
`define SPR_RX_RST_BIT   7
`define SPR_TX_RST_BIT   6
`define SPR_BUF_BIT      0

// reset values
`define SPR_TX_RDY_RST   1'b1
`define SPR_RX_RDY_RST   1'b0
`define SPR_RST_CTL_RST  1'b0
`define SPR_FLAG_RST     1'b0
`define SPR_WORD_RST     16'h0000
`define SPR_DATA_RST     32'h0000_0000

// data word width of the port
`define SPR_WORD_W       16

`endif

// ### hw/spr_pkg.sv
package spr_pkg;

  // register selected by an address phase
  typedef enum logic [2:0] {
    SPR_SEL_NONE,
    SPR_SEL_CTRL,
    SPR_SEL_TXW,
    SPR_SEL_RXW,
    SPR_SEL_CFG
  } spr_sel_type;

endpackage

// ### hw/spr_sync.sv
`timescale 1ns/100ps

// two-flop synchroniser, one lane per bit
module spr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;  // first stage, read only by second stage
  logic [WIDTH-1:0] sync_reg;  // second stage, safe to use

  // first stage feeds the second and nothing else
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // spr_sync

// ### hw/spr_ctrl.sv
// Overview of operation
// - transmit ready rises when word moves to shifter
// - transmit ready rise raises transmit interrupt request
// - standard follows shifter copy; buffered follows frame sync, not copy
// - transmit ready held one under any transmitter reset
// - receive ready rises when received word is held
// - receive ready rise raises receive interrupt request
// - receive ready held zero under any receiver reset
// - bit nine shows synchronised transmit clock pin
// - bit eight shows synchronised receive clock pin
// - bit seven enables receiver, resets to zero
// - writing receiver reset zero clears overrun, ready
// - bit six enables transmitter, resets to zero
// - transmitter reset write while not ready interrupts
// - transmitter reset write flags underflow (bit low), sets ready
`timescale 1ns/100ps
`include "spr_defs.svh"

module spr_ctrl (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  // ahb-lite slave
  input  wire logic                   hsel_i,
  input  wire logic [31:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  output logic [31:0]                 hrdata_o,
  // pins from the serial partner
  input  wire logic                   tx_bit_clock_i,
  input  wire logic                   rx_bit_clock_i,
  input  wire logic                   tx_frame_sync_i,
  // shifter side, same clock
  input  wire logic                   tx_copy_done_i,
  input  wire logic                   tx_underflow_event_i,
  input  wire logic                   rx_copy_done_i,
  input  wire logic                   rx_overrun_event_i,
  input  wire logic [`SPR_WORD_W-1:0] rx_word_i,
  output logic                        tx_enable_o,
  output logic                        rx_enable_o,
  output logic [`SPR_WORD_W-1:0]      tx_holding_word_o,
  output logic                        tx_word_valid_o,
  output logic                        tx_interrupt_request_o,
  output logic                        rx_interrupt_request_o
);

  // bus state
  logic                    wr_pend_reg,  wr_pend_next;   // write data phase due
  spr_pkg::spr_sel_type    wr_sel_reg,   wr_sel_next;    // register of that write
  logic [31:0]             rdata_reg,    rdata_next;     // read data, held
  // port state
  logic                    tx_rst_n_reg, tx_rst_n_next;  // transmitter enable
  logic                    rx_rst_n_reg, rx_rst_n_next;  // receiver enable
  logic                    tx_rdy_reg,   tx_rdy_next;    // transmit ready flag
  logic                    rx_rdy_reg,   rx_rdy_next;    // receive ready flag
  logic                    ovr_reg,      ovr_next;       // receive overrun flag
  logic                    udf_n_reg,    udf_n_next;     // active-low underflow
  logic                    tx_pend_reg,  tx_pend_next;   // word waiting for shifter
  logic                    buf_reg,      buf_next;       // buffered variant select
  logic [`SPR_WORD_W-1:0]  txw_reg,      txw_next;       // transmit holding word
  logic [`SPR_WORD_W-1:0]  rxw_reg,      rxw_next;       // receive holding word
  logic                    fs_dly_reg;                   // frame sync edge finder
  logic                    tx_irq_reg,   tx_irq_next;    // transmit request pulse
  logic                    rx_irq_reg,   rx_irq_next;    // receive request pulse
  // decodes
  logic [2:0]              pins_sync;                    // synchronised pins
  logic                    tx_lvl;                       // transmit clock level
  logic                    rx_lvl;                       // receive clock level
  logic                    fs_sync;                      // frame sync level
  logic                    fs_rise;                      // frame sync rising edge
  logic                    ap_valid;                     // address phase taken
  spr_pkg::spr_sel_type    ap_sel;                       // address phase target
  logic                    wr_ctrl;                      // control write data phase
  logic                    wr_txw;                       // holding word write
  logic                    wr_cfg;                       // config write
  logic                    rd_rxw;                       // receive word read

  // pins cross into the core domain through two flops
  spr_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    ({tx_frame_sync_i, tx_bit_clock_i, rx_bit_clock_i}),
    .sync_o     (pins_sync)
  );

  assign rx_lvl  = pins_sync[0];
  assign tx_lvl  = pins_sync[1];
  assign fs_sync = pins_sync[2];
  assign fs_rise = fs_sync & ~fs_dly_reg;

  // address decode on the low address byte only, its word offsets below 0x10 are mapped
  always_comb
  begin
    unique case (haddr_i[7:0])
      `SPR_CTRL_OFS: ap_sel = spr_pkg::SPR_SEL_CTRL;
      `SPR_TXW_OFS:  ap_sel = spr_pkg::SPR_SEL_TXW;
      `SPR_RXW_OFS:  ap_sel = spr_pkg::SPR_SEL_RXW;
      `SPR_CFG_OFS:  ap_sel = spr_pkg::SPR_SEL_CFG;
      default:       ap_sel = spr_pkg::SPR_SEL_NONE;
    endcase
  end

  // htrans bit one covers nonseq and seq
  assign ap_valid = hsel_i & htrans_i[1] & hready_i;
  assign wr_ctrl  = wr_pend_reg & (wr_sel_reg == spr_pkg::SPR_SEL_CTRL);
  assign wr_txw   = wr_pend_reg & (wr_sel_reg == spr_pkg::SPR_SEL_TXW);
  assign wr_cfg   = wr_pend_reg & (wr_sel_reg == spr_pkg::SPR_SEL_CFG);
  assign rd_rxw   = ap_valid & ~hwrite_i & (ap_sel == spr_pkg::SPR_SEL_RXW);

  // next state of bus and port; write effects first, then read data
  always_comb
  begin
    wr_pend_next  = ap_valid & hwrite_i;
    wr_sel_next   = ap_valid ? ap_sel : spr_pkg::SPR_SEL_NONE;
    rdata_next    = rdata_reg;
    tx_rst_n_next = tx_rst_n_reg;
    rx_rst_n_next = rx_rst_n_reg;
    tx_rdy_next   = tx_rdy_reg;
    rx_rdy_next   = rx_rdy_reg;
    ovr_next      = ovr_reg;
    udf_n_next    = udf_n_reg;
    tx_pend_next  = tx_pend_reg;
    buf_next      = buf_reg;
    txw_next      = txw_reg;
    rxw_next      = rxw_reg;
    tx_irq_next   = 1'b0;
    rx_irq_next   = 1'b0;

    if (tx_pend_reg && (buf_reg ? fs_rise : tx_copy_done_i))
    begin
      tx_rdy_next  = 1'b1;
      tx_pend_next = 1'b0;
      udf_n_next   = 1'b1;
    end
    // new holding word wins over a copy of the old one
    if (wr_txw)
    begin
      txw_next     = hwdata_i[`SPR_WORD_W-1:0];
      tx_rdy_next  = 1'b0;
      tx_pend_next = 1'b1;
      // standard variant clears underflow on the write itself
      if (!buf_reg)
      begin
        udf_n_next = 1'b1;
      end
    end
    // underflow from the shifter wins over the write that clears it
    if (tx_underflow_event_i && tx_rst_n_reg)
    begin
      udf_n_next = 1'b0;
    end
    if (wr_cfg)
    begin
      buf_next = hwdata_i[`SPR_BUF_BIT];
    end

    // only the reset controls take written data
    if (wr_ctrl)
    begin
      rx_rst_n_next = hwdata_i[`SPR_RX_RST_BIT];
      tx_rst_n_next = hwdata_i[`SPR_TX_RST_BIT];
      if (!hwdata_i[`SPR_TX_RST_BIT] && !tx_rdy_reg)
      begin
        tx_irq_next = 1'b1;
      end
      if (!hwdata_i[`SPR_TX_RST_BIT])
      begin
        udf_n_next = 1'b0;
      end
    end

    if (!tx_rst_n_next)
    begin
      tx_rdy_next  = 1'b1;
      tx_pend_next = 1'b0;
    end

    // reading the receive word clears ready and overrun
    if (rd_rxw)
    begin
      rx_rdy_next = 1'b0;
      ovr_next    = 1'b0;
    end
    // set wins over the read clear
    if (rx_copy_done_i && rx_rst_n_reg)
    begin
      rxw_next    = rx_word_i;
      rx_rdy_next = 1'b1;
    end
    if (rx_overrun_event_i && rx_rst_n_reg)
    begin
      ovr_next = 1'b1;
    end
    if (!rx_rst_n_next)
    begin
      rx_rdy_next = 1'b0;
      ovr_next    = 1'b0;
    end

    if (tx_rdy_next && !tx_rdy_reg)
    begin
      tx_irq_next = 1'b1;
    end
    if (rx_rdy_next && !rx_rdy_reg)
    begin
      rx_irq_next = 1'b1;
    end

    // read data reflects writes of the previous data phase
    if (ap_valid && !hwrite_i)
    begin
      rdata_next = `SPR_DATA_RST;
      unique case (ap_sel)
        spr_pkg::SPR_SEL_CTRL:
        begin
          rdata_next[`SPR_OVR_BIT]    = ovr_next;
          rdata_next[`SPR_UDF_N_BIT]  = udf_n_next;
          rdata_next[`SPR_TX_RDY_BIT] = tx_rdy_next;
          rdata_next[`SPR_RX_RDY_BIT] = rx_rdy_next;
          rdata_next[`SPR_TX_LVL_BIT] = tx_lvl;
          rdata_next[`SPR_RX_LVL_BIT] = rx_lvl;
          rdata_next[`SPR_RX_RST_BIT] = rx_rst_n_next;
          rdata_next[`SPR_TX_RST_BIT] = tx_rst_n_next;
        end
        spr_pkg::SPR_SEL_TXW:  rdata_next[`SPR_WORD_W-1:0] = txw_next;
        spr_pkg::SPR_SEL_RXW:  rdata_next[`SPR_WORD_W-1:0] = rxw_reg;
        spr_pkg::SPR_SEL_CFG:  rdata_next[`SPR_BUF_BIT]    = buf_next;
        spr_pkg::SPR_SEL_NONE: rdata_next = `SPR_DATA_RST;
      endcase
    end
  end

  // register everything; slave is always ready, always okay
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_pend_reg  <= 1'b0;
      wr_sel_reg   <= spr_pkg::SPR_SEL_NONE;
      rdata_reg    <= `SPR_DATA_RST;
      tx_rst_n_reg <= `SPR_RST_CTL_RST;
      rx_rst_n_reg <= `SPR_RST_CTL_RST;
      tx_rdy_reg   <= `SPR_TX_RDY_RST;
      rx_rdy_reg   <= `SPR_RX_RDY_RST;
      ovr_reg      <= `SPR_FLAG_RST;
      udf_n_reg    <= `SPR_FLAG_RST;
      tx_pend_reg  <= 1'b0;
      buf_reg      <= 1'b0;
      txw_reg      <= `SPR_WORD_RST;
      rxw_reg      <= `SPR_WORD_RST;
      fs_dly_reg   <= 1'b0;
      tx_irq_reg   <= 1'b0;
      rx_irq_reg   <= 1'b0;
    end
    else
    begin
      wr_pend_reg  <= wr_pend_next;
      wr_sel_reg   <= wr_sel_next;
      rdata_reg    <= rdata_next;
      tx_rst_n_reg <= tx_rst_n_next;
      rx_rst_n_reg <= rx_rst_n_next;
      tx_rdy_reg   <= tx_rdy_next;
      rx_rdy_reg   <= rx_rdy_next;
      ovr_reg      <= ovr_next;
      udf_n_reg    <= udf_n_next;
      tx_pend_reg  <= tx_pend_next;
      buf_reg      <= buf_next;
      txw_reg      <= txw_next;
      rxw_reg      <= rxw_next;
      fs_dly_reg   <= fs_sync;
      tx_irq_reg   <= tx_irq_next;
      rx_irq_reg   <= rx_irq_next;
    end
  end

  assign hreadyout_o            = 1'b1;
  assign hresp_o                = 1'b0;
  assign hrdata_o               = rdata_reg;
  assign tx_enable_o            = tx_rst_n_reg;
  assign rx_enable_o            = rx_rst_n_reg;
  assign tx_holding_word_o      = txw_reg;
  assign tx_word_valid_o        = tx_pend_reg;
  assign tx_interrupt_request_o = tx_irq_reg;
  assign rx_interrupt_request_o = rx_irq_reg;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence std_copy_s;
    !buf_reg && tx_pend_reg && tx_copy_done_i && !wr_txw && !wr_ctrl && tx_rst_n_reg;
  endsequence
  sequence buf_copy_only_s;
    buf_reg && tx_rst_n_reg && tx_copy_done_i && !fs_rise && !tx_rdy_reg && !wr_ctrl;
  endsequence
  sequence tx_pin_held_s;
    tx_bit_clock_i [*3];
  endsequence
  sequence rx_pin_held_s;
    rx_bit_clock_i [*3];
  endsequence

  tx_copy_ready_a: assert property (std_copy_s |=> tx_rdy_reg)
    else $error("transmit ready not set after copy");
  tx_rise_irq_a: assert property ($rose(tx_rdy_reg) |-> tx_interrupt_request_o)
    else $error("transmit ready rose without request");
  buf_needs_sync_a: assert property (buf_copy_only_s |=> !tx_rdy_reg)
    else $error("buffered ready set without frame sync");
  tx_rst_hold_a: assert property (!tx_rst_n_reg |-> tx_rdy_reg && !tx_pend_reg)
    else $error("transmit ready low while transmitter reset");
  rx_rise_irq_a: assert property ($rose(rx_rdy_reg) |-> rx_interrupt_request_o)
    else $error("receive ready rose without request");
  rx_rst_hold_a: assert property (!rx_rst_n_reg |-> !rx_rdy_reg)
    else $error("receive ready high while receiver reset");
  tx_level_a: assert property (tx_pin_held_s |-> tx_lvl)
    else $error("transmit clock level not shown");
  rx_level_a: assert property (rx_pin_held_s |-> rx_lvl)
    else $error("receive clock level not shown");
  rx_enable_a: assert property (wr_ctrl |=> rx_enable_o == $past(hwdata_i[`SPR_RX_RST_BIT]))
    else $error("receiver enable not written");
  rx_rst_clear_a: assert property (wr_ctrl && !hwdata_i[`SPR_RX_RST_BIT] |=> !rx_rdy_reg && !ovr_reg)
    else $error("receiver reset write did not clear flags");
  tx_rst_irq_a: assert property (wr_ctrl && !hwdata_i[`SPR_TX_RST_BIT] && !tx_rdy_reg
                                 |=> tx_interrupt_request_o)
    else $error("transmitter reset write gave no request");
  tx_rst_write_a: assert property (wr_ctrl && !hwdata_i[`SPR_TX_RST_BIT] |=> !udf_n_reg && tx_rdy_reg)
    else $error("transmitter reset write effects missing");

endmodule // spr_ctrl

// ### testbench/spr_partner.sv
`timescale 1ns/100ps

// far-side serial partner: owns both bit clocks and the frame sync pin
module spr_partner (
  input  wire logic       frame_req_i,     // start one short frame
  input  wire logic [1:0] idle_lvl_i,      // parked {tx, rx} clock levels
  output logic            tx_bit_clock_o,
  output logic            rx_bit_clock_o,
  output logic            tx_frame_sync_o
);
  logic in_frame;  // clocks only run inside a frame
  logic tx_run;    // transmit clock while in a frame
  logic rx_run;    // receive clock while in a frame

  initial
  begin
    in_frame        = 1'b0;
    tx_run          = 1'b0;
    rx_run          = 1'b0;
    tx_frame_sync_o = 1'b0;
  end

  // clocks stand still at the parked level outside frames; continuous, so no start-up race
  assign tx_bit_clock_o = in_frame ? tx_run : idle_lvl_i[1];
  assign rx_bit_clock_o = in_frame ? rx_run : idle_lvl_i[0];

  // one frame: sync high for the first bit, eight clock edges 16 ns apart (32 ns period)
  // edges sit 1 ns off the core clock edges so sampling is never a race
  always @(posedge frame_req_i)
  begin
    #1;
    {tx_run, rx_run} = idle_lvl_i;
    in_frame        = 1'b1;
    tx_frame_sync_o = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      #16;
      tx_run = ~tx_run;
      rx_run = ~rx_run;
      // sync lasts one whole bit clock so the core clock surely sees it
      if (i == 1)
        tx_frame_sync_o = 1'b0;
    end
    in_frame = 1'b0;
  end
endmodule // spr_partner

// ### testbench/tb_spr_ctrl.sv
`timescale 1ns/100ps

// self-checking bench for the serial port ready/reset control block
module tb_spr_ctrl;
  // one row: control write, parked pin levels, expected control read
  typedef struct packed {
    logic [15:0] wd;
    logic [1:0]  pins;
    logic [15:0] exp;
  } spr_row_type;

  logic        core_clk_i;
  logic        rst_b_i;
  logic        hsel_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic        hwrite_i;
  logic [31:0] hwdata_i;
  logic        hreadyout_o;
  logic        hresp_o;
  logic [31:0] hrdata_o;
  logic        tx_clk;
  logic        rx_clk;
  logic        fsync;
  logic [3:0]  shot_r;      // {tx copy, underflow, rx copy, overrun}
  logic [15:0] rx_word;
  logic        tx_en;
  logic        rx_en;
  logic [15:0] tx_word;
  logic        tx_valid;
  logic        tx_irq;
  logic        rx_irq;
  logic        frame_req;
  logic [1:0]  idle_lvl;
  logic [31:0] rd;          // last read data
  int          failures;
  int          n_checks;
  int          tx_irqs;     // pulses seen
  int          rx_irqs;
  int          exp_tx;      // pulses expected
  int          exp_rx;
  spr_row_type rows [5] = '{
    {16'hFFFF, 2'b00, 16'h08C0},
    {16'h0040, 2'b10, 16'h0A40},
    {16'h0080, 2'b01, 16'h0980},
    {16'hFF3F, 2'b11, 16'h0B00},
    {16'h0000, 2'b00, 16'h0800}
  };

  spr_ctrl u_dut (
    .core_clk_i             (core_clk_i),
    .rst_b_i                (rst_b_i),
    .hsel_i                 (hsel_i),
    .haddr_i                (haddr_i),
    .htrans_i               (htrans_i),
    .hwrite_i               (hwrite_i),
    .hsize_i                (3'h2),
    .hwdata_i               (hwdata_i),
    .hready_i               (hreadyout_o),
    .hreadyout_o            (hreadyout_o),
    .hresp_o                (hresp_o),
    .hrdata_o               (hrdata_o),
    .tx_bit_clock_i         (tx_clk),
    .rx_bit_clock_i         (rx_clk),
    .tx_frame_sync_i        (fsync),
    .tx_copy_done_i         (shot_r[3]),
    .tx_underflow_event_i   (shot_r[2]),
    .rx_copy_done_i         (shot_r[1]),
    .rx_overrun_event_i     (shot_r[0]),
    .rx_word_i              (rx_word),
    .tx_enable_o            (tx_en),
    .rx_enable_o            (rx_en),
    .tx_holding_word_o      (tx_word),
    .tx_word_valid_o        (tx_valid),
    .tx_interrupt_request_o (tx_irq),
    .rx_interrupt_request_o (rx_irq)
  );

  spr_partner u_partner (
    .frame_req_i     (frame_req),
    .idle_lvl_i      (idle_lvl),
    .tx_bit_clock_o  (tx_clk),
    .rx_bit_clock_o  (rx_clk),
    .tx_frame_sync_o (fsync)
  );

  // 250 MHz core clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  // count one-cycle interrupt pulses; a stuck level shows as too many
  always @(posedge core_clk_i)
  begin
    if (tx_irq === 1'b1)
      tx_irqs++;
    if (rx_irq === 1'b1)
      rx_irqs++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single ahb-lite transfer; waits on hready, never on a cycle count
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd);
    @(posedge core_clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= wr;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {16'h0, wd};
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  // one-cycle shifter event pulses, then let flags settle
  task automatic shot(input logic [3:0] m);
    @(posedge core_clk_i);
    shot_r <= m;
    @(posedge core_clk_i);
    shot_r <= 4'h0;
    repeat (3) @(posedge core_clk_i);
  endtask

  task automatic complete_run();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    #20000;
    failures++;
    complete_run();
  end

  initial
  begin
    failures  = 0;
    n_checks  = 0;
    tx_irqs   = 0;
    rx_irqs   = 0;
    exp_tx    = 0;
    exp_rx    = 0;
    rst_b_i   = 1'b0;
    hsel_i    = 1'b0;
    haddr_i   = 32'h0;
    htrans_i  = 2'h0;
    hwrite_i  = 1'b0;
    hwdata_i  = 32'h0;
    shot_r    = 4'h0;
    rx_word   = 16'h0;
    frame_req = 1'b0;
    idle_lvl  = 2'b00;
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    // reset values, okay response, unmapped address reads zero
    bus(0, 8'h00, 16'h0);
    check(rd, 32'h0800);
    check({31'h0, hresp_o}, 32'h0);
    bus(0, 8'h10, 16'h0);
    check(rd, 32'h0);
    // table: only bits 7 and 6 take writes, bits 9 and 8 follow the pins
    foreach (rows[i])
    begin
      idle_lvl <= rows[i].pins;
      bus(1, 8'h00, rows[i].wd);
      bus(0, 8'h00, 16'h0);
      check(rd, {16'h0, rows[i].exp});
      check({30'h0, rx_en, tx_en}, {30'h0, rows[i].exp[7:6]});
    end
    // standard variant: holding write drops ready, shifter copy raises it
    bus(1, 8'h00, 16'h0040);
    bus(1, 8'h04, 16'h1234);
    bus(0, 8'h00, 16'h0);
    check(rd & 32'h0800, 32'h0);
    check({15'h0, tx_valid, tx_word}, 32'h0001_1234);
    shot(4'h8);
    exp_tx++;
    check(tx_irqs, exp_tx);
    bus(0, 8'h00, 16'h0);
    check(rd & 32'h0800, 32'h0800);
    // transmitter reset written while not ready
    bus(1, 8'h04, 16'h5678);
    shot(4'h4);
    bus(0, 8'h00, 16'h0);
    check(rd, 32'h0040);
    bus(1, 8'h04, 16'h5678);
    bus(0, 8'h00, 16'h0);
    check(rd, 32'h1040);
    bus(1, 8'h00, 16'h0000);
    exp_tx++;
    repeat (2) @(posedge core_clk_i);
    check(tx_irqs, exp_tx);
    bus(0, 8'h00, 16'h0);
    check(rd, 32'h0800);
    // holding write with transmitter held in reset leaves ready high
    bus(1, 8'h04, 16'h9ABC);
    bus(0, 8'h00, 16'h0);
    check(rd, 32'h1800);
    // receive path: copy, read, overrun, receiver reset
    bus(1, 8'h00, 16'h0080);
    rx_word <= 16'hBEEF;
    shot(4'h2);
    exp_rx++;
    check(rx_irqs, exp_rx);
    bus(0, 8'h00, 16'h0);
    check(rd, 32'h0C80);
    bus(0, 8'h08, 16'h0);
    check(rd, 32'h0000_BEEF);
    shot(4'h2);
    shot(4'h1);
    exp_rx++;
    bus(0, 8'h00, 16'h0);
    check(rd, 32'h2C80);
    bus(1, 8'h00, 16'h0000);
    bus(0, 8'h00, 16'h0);
    check(rd, 32'h0800);
    // receiver held in reset ignores a copy
    shot(4'h2);
    bus(0, 8'h00, 16'h0);
    check(rd, 32'h0800);
    check(rx_irqs, exp_rx);
    // buffered variant: copy alone is not enough, frame sync completes it
    bus(1, 8'h0C, 16'h0001);
    bus(1, 8'h00, 16'h0040);
    bus(1, 8'h04, 16'h00AA);
    shot(4'h8);
    bus(0, 8'h00, 16'h0);
    check(rd & 32'h0800, 32'h0);
    frame_req <= 1'b1;
    repeat (40) @(posedge core_clk_i);
    frame_req <= 1'b0;
    exp_tx++;
    check(tx_irqs, exp_tx);
    bus(0, 8'h00, 16'h0);
    check(rd & 32'h0800, 32'h0800);
    complete_run();
  end
endmodule // tb_spr_ctrl
